// File: src/ddrcke_defs.svh
// Timing counts, field positions and the mode register select for the clock-enable command logic
// Assumes inclusion by bare name from package and modules
`ifndef DDRCKE_DEFS_SVH
`define DDRCKE_DEFS_SVH
`define DDRCKE_CLK_MHZ        250
`define DDRCKE_TCKEMIN_CK     3
`define DDRCKE_TXS_NS         170
`define DDRCKE_TXS_CK         ((`DDRCKE_TXS_NS * `DDRCKE_CLK_MHZ + 999) / 1000)
`define DDRCKE_TXSDLL_CK      512
`define DDRCKE_BURST_CK       4
`define DDRCKE_DLL_OFF_CL     6
`define DDRCKE_DLL_OFF_CWL    6
`define DDRCKE_AL             0
`define DDRCKE_MR_DLL_BIT     0
`define DDRCKE_MR1_SEL        3'h1
`define DDRCKE_CNT_W          10
`define DDRCKE_LAT_W          5
`endif

// File: src/ddrcke_pkg.sv
// Types for the two ends of the clock-enable command link: command and state for the device, request for the controller
// Assumes the defines header is on the include path
package ddrcke_pkg;
  `include "ddrcke_defs.svh"
  typedef enum logic [3:0] {
    DDRCKE_C_DES, DDRCKE_C_NOP, DDRCKE_C_MRS, DDRCKE_C_REF, DDRCKE_C_PRE,
    DDRCKE_C_ACT, DDRCKE_C_WR, DDRCKE_C_RD, DDRCKE_C_ZQ, DDRCKE_C_BAD
  } ddrcke_cmd_type;
  typedef enum logic [2:0] {
    DDRCKE_S_IDLE, DDRCKE_S_ACTIVE, DDRCKE_S_PPD, DDRCKE_S_APD, DDRCKE_S_SREF, DDRCKE_S_XS
  } ddrcke_state_type;
  typedef enum logic [3:0] {
    DDRCKE_R_NONE, DDRCKE_R_ACT, DDRCKE_R_PRE, DDRCKE_R_RD, DDRCKE_R_WR,
    DDRCKE_R_PDN, DDRCKE_R_SREF, DDRCKE_R_WAKE, DDRCKE_R_DLL_OFF, DDRCKE_R_DLL_ON,
    DDRCKE_R_ODT
  } ddrcke_req_type;
endpackage

// File: src/ddrcke_if.sv
// Command and clock-enable pins between memory controller and memory device
// Assumes both ends run on the same clock
`timescale 1ns/1ns
interface ddrcke_if;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        cke;
  logic        odt;
  logic        reset_n;
  logic [2:0]  ba;
  logic [15:0] addr;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, reset_n, ba, addr);
  modport dev  (input  cs_n, ras_n, cas_n, we_n, cke, odt, reset_n, ba, addr);
endinterface

// File: src/ddrcke_device.sv
// Device end: samples command and clock-enable pins, tracks power state
// Assumes pins come from another chip and pass a two-stage synchroniser
`timescale 1ns/1ns
`include "ddrcke_defs.svh"
module ddrcke_device (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  ddrcke_if.dev                          pins,
  output logic                           idle,
  output logic                           self_refresh,
  output logic                           power_down,
  output logic                           active_pd,
  output logic                           odt_enabled,
  output logic                           dll_off,
  output logic                           burst_busy,
  output logic                           refresh_busy,
  output logic                           illegal,
  output logic [`DDRCKE_LAT_W-1:0]       read_strobe_lat,
  output logic [7:0]                     banks_open
);
  import ddrcke_pkg::*;

  logic [24:0] sync1_r;
  logic [24:0] sync2_r;
  logic        rst_pin1_r;
  logic        rst_pin2_r;
  logic        cke_prev_r;
  ddrcke_state_type state_r;
  logic [`DDRCKE_CNT_W-1:0] burst_cnt_r;
  logic [`DDRCKE_CNT_W-1:0] xs_cnt_r;
  logic [`DDRCKE_CNT_W-1:0] cke_cnt_r;
  logic [15:0] mr1_r;
  logic [`DDRCKE_LAT_W-1:0] cl_r;

  logic        s_cs_n, s_ras_n, s_cas_n, s_we_n, s_cke, s_odt;
  logic [2:0]  s_ba;
  logic [15:0] s_addr;
  ddrcke_cmd_type cmd;

  function automatic ddrcke_cmd_type decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    if (cs_n) begin
      return DDRCKE_C_DES;
    end
    unique case ({ras_n, cas_n, we_n})
      3'h7: return DDRCKE_C_NOP;
      3'h0: return DDRCKE_C_MRS;
      3'h1: return DDRCKE_C_REF;
      3'h2: return DDRCKE_C_PRE;
      3'h3: return DDRCKE_C_ACT;
      3'h4: return DDRCKE_C_WR;
      3'h5: return DDRCKE_C_RD;
      3'h6: return DDRCKE_C_ZQ;
      default: return DDRCKE_C_BAD;
    endcase
  endfunction

  // Pins cross from the other chip through two stages
  always_ff @(posedge clk) begin
    sync1_r    <= {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.cke, pins.odt,
                   pins.ba, pins.addr};
    sync2_r    <= sync1_r;
    rst_pin1_r <= pins.reset_n;
    rst_pin2_r <= rst_pin1_r;
  end

  assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_cke, s_odt, s_ba, s_addr} = sync2_r;
  assign cmd = decode(s_cs_n, s_ras_n, s_cas_n, s_we_n);

  wire dev_rst = !rstn || !rst_pin2_r;
  wire cke_fall = cke_prev_r && !s_cke;
  wire cke_rise = !cke_prev_r && s_cke;
  wire cke_early = (cke_fall || cke_rise) &&
                   (cke_cnt_r < `DDRCKE_CNT_W'(`DDRCKE_TCKEMIN_CK - 1));
  wire quiet = (cmd == DDRCKE_C_NOP) || (cmd == DDRCKE_C_DES);
  wire bursting = (burst_cnt_r != '0);
  wire all_closed = (banks_open == 8'h00);

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      // Enable idles high, so no false edge follows reset
      cke_prev_r <= 1'b1;
      cke_cnt_r  <= `DDRCKE_CNT_W'(`DDRCKE_TCKEMIN_CK);
    end else begin
      cke_prev_r <= s_cke;
      if (s_cke != cke_prev_r) begin
        cke_cnt_r <= '0;
      end else if (cke_cnt_r != `DDRCKE_CNT_W'(`DDRCKE_TCKEMIN_CK)) begin
        cke_cnt_r <= cke_cnt_r + 1'b1;
      end
    end
  end

  // Power state machine; odt never consulted here
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      state_r <= DDRCKE_S_IDLE;
      xs_cnt_r <= '0;
    end else begin
      if (xs_cnt_r != '0) begin
        xs_cnt_r <= xs_cnt_r - 1'b1;
      end
      unique case (state_r)
        DDRCKE_S_IDLE, DDRCKE_S_ACTIVE: begin
          if (cke_fall && cmd == DDRCKE_C_REF && all_closed && !bursting) begin
            state_r <= DDRCKE_S_SREF;
          end else if (cke_fall && quiet) begin
            state_r <= all_closed ? DDRCKE_S_PPD : DDRCKE_S_APD;
          end else begin
            state_r <= all_closed ? DDRCKE_S_IDLE : DDRCKE_S_ACTIVE;
          end
        end
        DDRCKE_S_PPD, DDRCKE_S_APD: begin
          if (cke_rise) begin
            state_r <= all_closed ? DDRCKE_S_IDLE : DDRCKE_S_ACTIVE;
          end
        end
        DDRCKE_S_SREF: begin
          if (s_cke) begin
            state_r  <= DDRCKE_S_XS;
            xs_cnt_r <= `DDRCKE_CNT_W'(`DDRCKE_TXSDLL_CK);
          end
        end
        DDRCKE_S_XS: begin
          if (xs_cnt_r == '0) begin
            state_r <= DDRCKE_S_IDLE;
          end
        end
        default: state_r <= DDRCKE_S_IDLE;
      endcase
    end
  end

  wire take = s_cke && cke_prev_r &&
              (state_r == DDRCKE_S_IDLE || state_r == DDRCKE_S_ACTIVE);

  // Bank tracking and burst counter; bursts cannot be cut short
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      banks_open  <= 8'h00;
      burst_cnt_r <= '0;
    end else begin
      if (bursting) begin
        burst_cnt_r <= burst_cnt_r - 1'b1;
      end
      if (take) begin
        unique case (cmd)
          DDRCKE_C_ACT: banks_open[s_ba] <= 1'b1;
          DDRCKE_C_PRE: begin
            if (s_addr[10]) begin
              banks_open <= 8'h00;
            end else begin
              banks_open[s_ba] <= 1'b0;
            end
          end
          DDRCKE_C_RD, DDRCKE_C_WR: begin
            if (!bursting) begin
              burst_cnt_r <= `DDRCKE_CNT_W'(`DDRCKE_BURST_CK);
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Mode register one write; bank address picks the register
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      mr1_r <= 16'h0000;
      cl_r  <= `DDRCKE_LAT_W'(`DDRCKE_DLL_OFF_CL);
    end else if (take && cmd == DDRCKE_C_MRS && s_ba == `DDRCKE_MR1_SEL) begin
      mr1_r <= s_addr;
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      idle            <= 1'b0;
      self_refresh    <= 1'b0;
      power_down      <= 1'b0;
      active_pd       <= 1'b0;
      odt_enabled     <= 1'b0;
      dll_off         <= 1'b0;
      burst_busy      <= 1'b0;
      refresh_busy    <= 1'b0;
      illegal         <= 1'b0;
      read_strobe_lat <= '0;
    end else begin
      idle         <= state_r == DDRCKE_S_IDLE && all_closed && !bursting && s_cke;
      self_refresh <= state_r == DDRCKE_S_SREF;
      power_down   <= state_r == DDRCKE_S_PPD || state_r == DDRCKE_S_APD;
      active_pd    <= state_r == DDRCKE_S_APD;
      odt_enabled  <= s_odt && state_r != DDRCKE_S_SREF;
      dll_off      <= mr1_r[`DDRCKE_MR_DLL_BIT];
      burst_busy   <= bursting;
      refresh_busy <= take && cmd == DDRCKE_C_REF;
      illegal      <= (take && cmd == DDRCKE_C_BAD) ||
                      ((cke_fall || cke_rise) && !quiet &&
                       !(cke_fall && cmd == DDRCKE_C_REF)) ||
                      cke_early ||
                      (state_r == DDRCKE_S_XS && !quiet);
      read_strobe_lat <= mr1_r[`DDRCKE_MR_DLL_BIT] ?
                         `DDRCKE_LAT_W'(`DDRCKE_AL) + cl_r - 1'b1 :
                         `DDRCKE_LAT_W'(`DDRCKE_AL) + cl_r;
    end
  end
endmodule

// File: src/ddrcke_ctrl.sv
// Controller end: drives command and clock-enable pins from simple requests
// Assumes requests arrive on the same clock
`timescale 1ns/1ns
`include "ddrcke_defs.svh"
module ddrcke_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  ddrcke_if.ctrl                     pins,
  input  wire ddrcke_pkg::ddrcke_req_type req,
  input  wire logic [2:0]            req_ba,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  output logic                       in_low_power
);
  import ddrcke_pkg::*;

  logic [`DDRCKE_CNT_W-1:0] wait_r;
  logic [`DDRCKE_CNT_W-1:0] hold_r;
  logic                     asleep_r;

  wire can_go = (wait_r == '0) && (hold_r == '0);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pins.cs_n <= 1'b1;
      pins.ras_n <= 1'b1;
      pins.cas_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.cke <= 1'b1;
      pins.odt <= 1'b0;
      pins.reset_n <= 1'b0;
      pins.ba <= 3'h0;
      pins.addr <= 16'h0000;
      wait_r <= '0;
      hold_r <= '0;
      asleep_r <= 1'b0;
      req_ready <= 1'b0;
      in_low_power <= 1'b0;
    end else begin
      pins.reset_n <= 1'b1;
      pins.cs_n <= 1'b1;
      pins.ras_n <= 1'b1;
      pins.cas_n <= 1'b1;
      pins.we_n <= 1'b1;
      if (wait_r != '0) begin
        wait_r <= wait_r - 1'b1;
      end
      if (hold_r != '0) begin
        hold_r <= hold_r - 1'b1;
      end
      req_ready <= can_go && !req_valid;
      if (req_valid && can_go) begin
        pins.ba <= req_ba;
        unique case (req)
          DDRCKE_R_ACT: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h3;
          DDRCKE_R_PRE: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h2;
          DDRCKE_R_RD, DDRCKE_R_WR: begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= (req == DDRCKE_R_RD) ? 4'h5 : 4'h4;
            wait_r <= `DDRCKE_CNT_W'(`DDRCKE_BURST_CK);
          end
          DDRCKE_R_PDN: begin
            pins.cke <= 1'b0;
            hold_r <= `DDRCKE_CNT_W'(`DDRCKE_TCKEMIN_CK);
            asleep_r <= 1'b1;
          end
          DDRCKE_R_SREF: begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h1;
            pins.cke <= 1'b0;
            hold_r <= `DDRCKE_CNT_W'(`DDRCKE_TCKEMIN_CK);
            asleep_r <= 1'b1;
          end
          DDRCKE_R_WAKE: begin
            pins.cke <= 1'b1;
            hold_r <= `DDRCKE_CNT_W'(`DDRCKE_TCKEMIN_CK);
            wait_r <= `DDRCKE_CNT_W'(`DDRCKE_TXSDLL_CK);
            asleep_r <= 1'b0;
          end
          // Mode register write; bank address names the register
          DDRCKE_R_DLL_OFF, DDRCKE_R_DLL_ON: begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h0;
            pins.addr <= 16'(req == DDRCKE_R_DLL_OFF) << `DDRCKE_MR_DLL_BIT;
          end
          DDRCKE_R_ODT: pins.odt <= req_ba[0];
          default: ;
        endcase
      end
      in_low_power <= asleep_r;
    end
  end
endmodule

// File: verif/ddrcke_chk.sv
// Checker on the pins between controller and device ends
// Assumes one clock and synchronous active-low reset for both ends
`timescale 1ns/1ns
`include "ddrcke_defs.svh"
module ddrcke_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic reset_n
);
  localparam int TXS    = `DDRCKE_TXS_CK;
  localparam int TXSDLL = `DDRCKE_TXSDLL_CK;
  logic       quiet;
  logic       ref_c;
  logic       rdwr;
  logic       sre;
  logic       cke_r;
  logic       in_sr_r;
  logic [9:0] xs_r;
  logic [9:0] dll_r;
  assign quiet = cs_n || (ras_n && cas_n && we_n);
  assign ref_c = !cs_n && !ras_n && !cas_n && we_n;
  assign rdwr  = !cs_n && ras_n && !cas_n;
  assign sre   = cke_r && !cke && ref_c;
  always_ff @(posedge clk) begin
    if (!rstn) cke_r <= 1'b1;
    else cke_r <= cke;
  end
  always_ff @(posedge clk) begin
    if (!rstn) in_sr_r <= 1'b0;
    else if (sre) in_sr_r <= 1'b1;
    else if (cke) in_sr_r <= 1'b0;
  end
  // Exit windows counted from the edge that registers enable high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      xs_r  <= 10'h000;
      dll_r <= 10'h000;
    end else if (in_sr_r && cke) begin
      xs_r  <= 10'(TXS);
      dll_r <= 10'(TXSDLL - 1);
    end else begin
      xs_r  <= (xs_r != 10'h000) ? xs_r - 10'h001 : xs_r;
      dll_r <= (dll_r != 10'h000) ? dll_r - 10'h001 : dll_r;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  reset_pin_high_a: assert property ($past(rstn) |-> reset_n)
    else $error("reset pin low in normal use");
  entry_quiet_a: assert property ($fell(cke) |-> quiet || ref_c)
    else $error("command on enable fall");
  exit_quiet_a: assert property ($rose(cke) |-> quiet)
    else $error("command on enable rise");
  cke_hold_a: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("enable changed too soon");
  xs_quiet_a: assert property (xs_r != 10'h000 |-> quiet)
    else $error("command inside exit wait");
  xsdll_read_a: assert property (dll_r != 10'h000 |-> !(rdwr && we_n))
    else $error("read before lock wait");
  burst_whole_a: assert property (rdwr |=> quiet [*3])
    else $error("burst interrupted");
  no_sre_burst_a: assert property (rdwr |-> ##1 !sre [*4])
    else $error("self refresh during burst");
endmodule

// File: verif/sdram_cke_command_state_logic_tb.sv
// Bench joining controller and device ends over the pin interface
// Assumes the defines header is on the include path
`timescale 1ns/1ns
`include "ddrcke_defs.svh"
module sdram_cke_command_state_logic_tb;
  import ddrcke_pkg::*;
  logic           clk = 1'b0;
  logic           rstn = 1'b0;
  logic           req_valid = 1'b0;
  logic [2:0]     req_ba = 3'h0;
  ddrcke_req_type req = DDRCKE_R_NONE;
  logic           req_ready, in_low_power, odd_seen = 1'b0;
  logic           idle, self_refresh, power_down, active_pd, odt_enabled;
  logic           dll_off, burst_busy, refresh_busy, illegal;
  logic [4:0]     read_strobe_lat;
  logic [7:0]     banks_open;
  int             miscompares = 0;
  int             check_count = 0;
  always #2 clk = ~clk;
  ddrcke_if link ();
  ddrcke_ctrl u_ddrcke_ctrl (.clk(clk), .rstn(rstn), .pins(link.ctrl), .req(req),
    .req_ba(req_ba), .req_valid(req_valid), .req_ready(req_ready),
    .in_low_power(in_low_power));
  ddrcke_device u_ddrcke_device (.clk(clk), .rstn(rstn), .pins(link.dev), .idle(idle),
    .self_refresh(self_refresh), .power_down(power_down), .active_pd(active_pd),
    .odt_enabled(odt_enabled), .dll_off(dll_off), .burst_busy(burst_busy),
    .refresh_busy(refresh_busy), .illegal(illegal), .read_strobe_lat(read_strobe_lat),
    .banks_open(banks_open));
  ddrcke_chk u_ddrcke_chk (.clk(clk), .rstn(rstn), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke), .reset_n(link.reset_n));
  // Sticky flag for illegal pulses or refresh inside power-down
  always @(negedge clk)
    if (rstn && (illegal === 1'b1 || (power_down === 1'b1 && refresh_busy === 1'b1)))
      odd_seen <= 1'b1;
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return idle;
      1: return power_down;
      2: return self_refresh;
      default: return burst_busy;
    endcase
  endfunction
  task automatic wait_on(int k, logic v, int lim);
    int n;
    n = 0;
    while (pick(k) !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask
  task automatic send(ddrcke_req_type r, logic [2:0] b);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 1000) begin
        miscompares++;
        tally_and_finish();
      end
    end
    req = r;
    req_ba = b;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic t_bank_pd;
    send(DDRCKE_R_ACT, 3'h2);
    wait_on(0, 1'b0, 20);
    chk("banks", banks_open, 8'h04);
    send(DDRCKE_R_PDN, 3'h0);
    wait_on(1, 1'b1, 20);
    chk("apd", active_pd, 8'h01);
    send(DDRCKE_R_WAKE, 3'h0);
    wait_on(1, 1'b0, 20);
    send(DDRCKE_R_PRE, 3'h2);
    wait_on(0, 1'b1, 20);
    chk("banks", banks_open, 8'h00);
    send(DDRCKE_R_PDN, 3'h0);
    wait_on(1, 1'b1, 20);
    chk("apd", active_pd, 8'h00);
    chk("idle", idle, 8'h00);
    send(DDRCKE_R_WAKE, 3'h0);
    wait_on(0, 1'b1, 700);
  endtask
  task automatic t_burst;
    send(DDRCKE_R_ACT, 3'h5);
    send(DDRCKE_R_RD, 3'h5);
    wait_on(3, 1'b1, 20);
    chk("idle", idle, 8'h00);
    wait_on(3, 1'b0, 20);
    send(DDRCKE_R_WR, 3'h5);
    send(DDRCKE_R_PRE, 3'h5);
    wait_on(0, 1'b1, 40);
    chk("banks", banks_open, 8'h00);
    chk("dll", dll_off, 8'h00);
    chk("lat", read_strobe_lat, 8'(`DDRCKE_AL + `DDRCKE_DLL_OFF_CL));
  endtask
  task automatic t_mode;
    send(DDRCKE_R_DLL_OFF, 3'h2);
    repeat (8) @(negedge clk);
    chk("dll", dll_off, 8'h00);
    send(DDRCKE_R_DLL_OFF, `DDRCKE_MR1_SEL);
    repeat (8) @(negedge clk);
    chk("dll", dll_off, 8'h01);
    chk("lat", read_strobe_lat, 8'(`DDRCKE_AL + `DDRCKE_DLL_OFF_CL - 1));
    send(DDRCKE_R_DLL_ON, `DDRCKE_MR1_SEL);
    repeat (8) @(negedge clk);
    chk("dll", dll_off, 8'h00);
    chk("lat", read_strobe_lat, 8'(`DDRCKE_AL + `DDRCKE_DLL_OFF_CL));
  endtask
  task automatic t_sref;
    send(DDRCKE_R_ODT, 3'h1);
    repeat (6) @(negedge clk);
    chk("odt", odt_enabled, 8'h01);
    send(DDRCKE_R_SREF, 3'h0);
    wait_on(2, 1'b1, 20);
    chk("odt", odt_enabled, 8'h00);
    chk("lowp", in_low_power, 8'h01);
    send(DDRCKE_R_WAKE, 3'h0);
    wait_on(2, 1'b0, 8);
    chk("idle", idle, 8'h00);
    wait_on(0, 1'b1, 700);
    chk("odt", odt_enabled, 8'h01);
    chk("odd", odd_seen, 8'h00);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    wait_on(0, 1'b1, 50);
    t_bank_pd();
    t_burst();
    t_mode();
    t_sref();
    tally_and_finish();
  end
endmodule
